// ---- core/clvp_core.sv ----
// character-line video pipeline: counters, line buffers, grey-level output
`timescale 1ns/100ps
module clvp_core (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        q_flag,
  input  wire logic        horizontal_pixel_tick_n,
  input  wire logic        display_cpu_phase_four,
  input  wire logic        dma_out,
  input  wire logic [7:0]  dma_data,
  input  wire logic        cursor_flag,
  input  wire logic        pixel_tick,
  input  wire logic [23:0] cg_data,
  input  wire logic        sync_req,
  output logic             dma_req,
  output logic      [11:0] cg_addr,
  output logic             last_scan_line,
  output logic      [3:0]  dac_level,
  output logic             dac_sync
);

  typedef struct packed {
    logic [1:0][clvp_pkg::LINE_CHARS-1:0][7:0] lbuf;
    logic             fill_sel;
    logic [6:0]       wr_idx;
    logic [6:0]       disp_len;
    logic [6:0]       rd_idx;
    logic [7:0]       len_cnt;
    logic             len_valid;
    logic [7:0]       scan_cnt;
    logic [4:0]       scan_row;
    logic             scan_pend;
    logic             hpt_sync;
    logic             hpt_prev;
    logic [7:0]       flags;
    logic [4:0]       hl_line;
    logic [2:0][7:0]  pf;
    logic [6:0]       pf_stat;
    logic [2:0][7:0]  sh;
    logic [6:0]       sh_stat;
    logic [2:0]       bit_cnt;
    logic             cg_pend;
    logic [11:0]      cg_addr;
    logic             dma_req;
    logic             last_scan;
    logic [3:0]       dac_level;
    logic             dac_sync;
    logic             wb_ack;
    logic [31:0]      wb_dat;
  } clvp_state_t;

  clvp_state_t st;
  clvp_state_t next_st;

  // grey level for one pixel from its three serial bits and status
  function automatic logic [3:0] clvp_xform(input logic [2:0] bits,
                                            input logic [6:0] stat,
                                            input logic [7:0] flags,
                                            input logic       under_row,
                                            input logic       blank_row);
    logic [2:0] g;
    logic       neg;
    begin
      g   = bits;
      neg = flags[clvp_pkg::FL_NEG] ^ stat[clvp_pkg::HB_REV];
      if (stat[clvp_pkg::ST_BLANK] || blank_row)
        g = 3'h0;
      if (stat[clvp_pkg::HB_BLK] && flags[clvp_pkg::FL_CBLINK])
        g = 3'h0;
      if (stat[clvp_pkg::HB_UND] && under_row)
        g = clvp_pkg::GREY_FULL;
      if (stat[clvp_pkg::ST_CURSOR] && under_row && !flags[clvp_pkg::FL_CURB])
        g = clvp_pkg::GREY_FULL;
      if (stat[clvp_pkg::HB_SEC])
        g = clvp_pkg::GREY_FULL;
      if (neg)
        g = ~g;
      if (stat[clvp_pkg::HB_BRT])
        clvp_xform = {g, 1'b0};
      else
        clvp_xform = {1'b0, g};
    end
  endfunction : clvp_xform

  // status for a fetched character; also returns the running highlight set
  function automatic logic [11:0] clvp_status(input logic [7:0] ch,
                                              input logic [4:0] hl,
                                              input logic [7:0] flags);
    logic [4:0] start;
    logic [4:0] run;
    logic       ctrl;
    begin
      start = 5'h00;
      ctrl  = 1'b1;
      case (ch[6:0])
        clvp_pkg::HL_REVERSE: start = 5'h01;
        clvp_pkg::HL_UNDER:   start = 5'h02;
        clvp_pkg::HL_BLINK:   start = 5'h04;
        clvp_pkg::HL_SECURE:  start = 5'h08;
        clvp_pkg::HL_BRIGHT:  start = 5'h10;
        clvp_pkg::HL_ALL: begin
          start = 5'h1f;
          ctrl  = 1'b0;                                             // diamond glyph
        end
        clvp_pkg::HL_FORMS_A, clvp_pkg::HL_FORMS_B: begin
          start = (flags[clvp_pkg::FL_FORMS] && flags[clvp_pkg::FL_NEG]) ? 5'h01 : 5'h00;
          ctrl  = 1'b0;
        end
        clvp_pkg::HL_STOP: start = 5'h00;
        default:           ctrl  = 1'b0;
      endcase
      run = hl | start;
      // status: cursor, blank, highlights; upper bits are the run-on set
      if (ch[6:0] == clvp_pkg::HL_STOP)
        clvp_status = {5'h00, ch[7], ctrl, run};
      else
        clvp_status = {run, ch[7], ctrl, run};
    end
  endfunction : clvp_status

  logic       tick;
  logic       end_strobe;
  logic       bus_req;
  logic       len_wr;
  logic       chr_dma;
  logic       scan_count_bit_zero;
  logic       scan_count_bit_one;
  logic       scan_count_bit_two;
  logic       do_fetch;
  logic [6:0] fetch_idx;
  logic [7:0] fetch_ch;
  logic [11:0] fstat;
  logic [2:0] pix_bits;
  logic [6:0] pix_stat;

  // phase-four resync of the pixel tick, then edge to one strobe
  assign tick       = st.hpt_sync && !st.hpt_prev;
  assign end_strobe = tick && (st.scan_cnt == clvp_pkg::CNT_MAX);
  assign bus_req    = wb_cyc_i && wb_stb_i && !st.wb_ack;
  // a length load wins over a character count on the same edge, so the load is never lost
  assign len_wr     = bus_req && wb_we_i && wb_sel_i[0]
                      && (wb_adr_i == clvp_pkg::ADR_LINE_LEN);
  assign chr_dma    = dma_out && !dma_data[7] && !st.scan_pend && st.len_valid
                      && (st.len_cnt != clvp_pkg::CNT_MAX);
  // underline rows are the last pair of an eight-pair cell
  assign scan_count_bit_zero = st.scan_cnt[0];
  assign scan_count_bit_one  = st.scan_cnt[1];
  assign scan_count_bit_two  = st.scan_cnt[2];

  always_comb begin
    next_st  = st;
    next_st.cg_pend = 1'b0;
    next_st.wb_ack  = bus_req;
    do_fetch  = 1'b0;
    fetch_idx = 7'h00;
    fetch_ch  = 8'h00;
    fstat     = 12'h000;
    pix_bits  = 3'h0;
    pix_stat  = 7'h00;
    next_st.hpt_prev = st.hpt_sync;
    if (display_cpu_phase_four)
      next_st.hpt_sync = !horizontal_pixel_tick_n;

    // register bus: one-cycle answer, unmapped reads give zero
    next_st.wb_dat = 32'h0000_0000;
    if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        clvp_pkg::ADR_LINE_LEN: next_st.wb_dat = {23'h0, st.len_valid, st.len_cnt};
        clvp_pkg::ADR_FLAGS:    next_st.wb_dat = {24'h0, st.flags};
        clvp_pkg::ADR_SCAN:     next_st.wb_dat = {13'h0, st.last_scan, st.fill_sel,
                                                  st.scan_pend, 1'b0, st.disp_len,
                                                  st.scan_cnt};
        default:                next_st.wb_dat = 32'h0000_0000;
      endcase
    end
    if (bus_req && wb_we_i && wb_sel_i[0]) begin
      case (wb_adr_i)
        clvp_pkg::ADR_LINE_LEN: begin
          next_st.len_cnt   = wb_dat_i[7:0];
          next_st.len_valid = 1'b1;
        end
        clvp_pkg::ADR_FLAGS: next_st.flags = wb_dat_i[7:0];
        default: ;
      endcase
    end

    // dma out cycle: scan load first, else status code, else character
    if (dma_out) begin
      if (st.scan_pend) begin
        next_st.scan_cnt  = dma_data;
        next_st.scan_row  = 5'h00;
        next_st.scan_pend = 1'b0;
      end else if (dma_data[7]) begin
        if (dma_data[7:4] == clvp_pkg::STAT_NIBBLE && dma_data[3:1] != clvp_pkg::FLAG_NONE)
          next_st.flags[dma_data[3:1]] = dma_data[0];
      end else if (chr_dma) begin
        if (st.wr_idx <= clvp_pkg::LINE_LAST) begin
          next_st.lbuf[st.fill_sel][st.wr_idx] = {cursor_flag, dma_data[6:0]};
          next_st.wr_idx = st.wr_idx + 7'h01;
        end
        if (!len_wr)
          next_st.len_cnt = st.len_cnt + 8'h01;
      end
    end

    // scan line pair counting and end of character line
    if (tick) begin
      if (end_strobe) begin
        next_st.scan_pend = 1'b1;
        next_st.fill_sel  = !st.fill_sel;
        // a character stored on the same edge still belongs to the finished line
        next_st.disp_len  = next_st.wr_idx;
        next_st.wr_idx    = 7'h00;
      end else begin
        next_st.scan_cnt = st.scan_cnt + 8'h01;
        if (st.scan_row != 5'h1f)
          next_st.scan_row = st.scan_row + 5'h01;
      end
      next_st.hl_line = 5'h00;
      next_st.bit_cnt = clvp_pkg::BIT_LAST;
      do_fetch  = 1'b1;
      fetch_idx = 7'h00;
    end
    if (q_flag) begin
      next_st.scan_cnt = 8'h00;
      next_st.scan_row = 5'h00;
    end

    // serializer: one bit per pixel tick, refill from prefetch on the last bit
    if (st.cg_pend)
      next_st.pf = cg_data;
    if (pixel_tick && !tick) begin
      pix_bits = (st.bit_cnt == clvp_pkg::BIT_LAST)
               ? {st.pf[2][7], st.pf[1][7], st.pf[0][7]}
               : {st.sh[2][7], st.sh[1][7], st.sh[0][7]};
      pix_stat = (st.bit_cnt == clvp_pkg::BIT_LAST) ? st.pf_stat : st.sh_stat;
      next_st.dac_level = clvp_xform(pix_bits, pix_stat, st.flags,
                                     scan_count_bit_zero && scan_count_bit_one
                                     && scan_count_bit_two,
                                     st.scan_row >= clvp_pkg::BLANK_ROW);
      if (st.bit_cnt == clvp_pkg::BIT_LAST) begin
        for (int i = 0; i < 3; i++)
          next_st.sh[i] = {st.pf[i][6:0], 1'b0};
        next_st.sh_stat = st.pf_stat;
        do_fetch  = 1'b1;
        fetch_idx = st.rd_idx + 7'h01;
      end else begin
        for (int i = 0; i < 3; i++)
          next_st.sh[i] = {st.sh[i][6:0], 1'b0};
      end
      next_st.bit_cnt = st.bit_cnt + 3'h1;
    end

    // fetch from the display buffer and address the generators
    if (do_fetch) begin
      if (fetch_idx < st.disp_len || (end_strobe && fetch_idx < st.wr_idx))
        fetch_ch = st.lbuf[!next_st.fill_sel][fetch_idx];
      else
        fetch_ch = {1'b0, clvp_pkg::HL_STOP};                       // past line end
      fstat = clvp_status(fetch_ch, next_st.hl_line, st.flags);
      next_st.pf_stat = fstat[6:0];
      next_st.hl_line = fstat[11:7];
      next_st.rd_idx  = fetch_idx;
      next_st.cg_addr = {fetch_ch[6:0], st.flags[clvp_pkg::FL_FIELD],
                         next_st.scan_row[3:0]};
      next_st.cg_pend = 1'b1;
    end
    if (sync_req)
      next_st.dac_level = 4'h0;
    next_st.dac_sync  = sync_req;

    // outputs follow the new state so ports and state agree
    next_st.dma_req = next_st.scan_pend ||
                      (next_st.len_valid && next_st.len_cnt != clvp_pkg::CNT_MAX);
    next_st.last_scan = (next_st.scan_cnt == clvp_pkg::CNT_MAX);
  end

  // single state register; everything clears on reset
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_o       = st.wb_dat;
  assign wb_ack_o       = st.wb_ack;
  assign dma_req        = st.dma_req;
  assign cg_addr        = st.cg_addr;
  assign last_scan_line = st.last_scan;
  assign dac_level      = st.dac_level;
  assign dac_sync       = st.dac_sync;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_len_write;
    bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == clvp_pkg::ADR_LINE_LEN;
  endsequence
  sequence s_end_line;
    end_strobe && !q_flag;
  endsequence

  a_len_load: assert property (s_len_write |=> st.len_valid
    && st.len_cnt == $past(wb_dat_i[7:0])) else $error("length load lost");
  a_req_invalid: assert property (!st.len_valid && !st.scan_pend |-> !dma_req)
    else $error("request without valid count");
  a_req_max: assert property (st.len_valid && st.len_cnt == clvp_pkg::CNT_MAX
    && !st.scan_pend |-> !dma_req) else $error("request at maximum");
  a_q_clear: assert property (q_flag |=> st.scan_cnt == 8'h00)
    else $error("q flag did not clear");
  a_scan_step: assert property ($changed(st.scan_cnt) |->
    $past(tick || q_flag || (dma_out && st.scan_pend))) else $error("stray count");
  a_end_req: assert property (s_end_line ##1 !dma_out |-> st.scan_pend && dma_req)
    else $error("end strobe gave no request");
  a_buf_swap: assert property (s_end_line |=> st.fill_sel != $past(st.fill_sel))
    else $error("buffers did not swap");
  a_chr_write: assert property (chr_dma && st.wr_idx <= clvp_pkg::LINE_LAST |=>
    st.lbuf[$past(st.fill_sel)][$past(st.wr_idx)] == $past({cursor_flag, dma_data[6:0]}))
    else $error("character not stored");
  a_last_line: assert property (last_scan_line == (st.scan_cnt == clvp_pkg::CNT_MAX)
    ##1 last_scan_line == (st.scan_cnt == clvp_pkg::CNT_MAX)) else $error("last line wrong");
  a_bright_even: assert property (pixel_tick && !tick && !sync_req && st.bit_cnt !=
    clvp_pkg::BIT_LAST && st.sh_stat[clvp_pkg::HB_BRT] |=> !dac_level[0])
    else $error("bright level odd");
  // sync, status codes, the buffer hand-over and the scan load request
  a_sync_out: assert property (sync_req |=> dac_sync && dac_level == 4'h0)
    else $error("sync level not forced");
  a_flag_code: assert property (dma_out && !st.scan_pend
    && dma_data[7:4] == clvp_pkg::STAT_NIBBLE && dma_data[3:1] != clvp_pkg::FLAG_NONE
    |=> st.flags[$past(dma_data[3:1])] == $past(dma_data[0])) else $error("status code lost");
  a_fill_reset: assert property (s_end_line |=> st.wr_idx == 7'h00)
    else $error("fill index not restarted");
  a_req_pend: assert property (st.scan_pend |-> dma_req)
    else $error("scan load not requested");

endmodule : clvp_core

// ---- shared/clvp_pkg.sv ----
// constants for the character-line video pipeline
package clvp_pkg;
  // register byte addresses on the bus
  localparam logic [3:0] ADR_LINE_LEN = 4'h0;
  localparam logic [3:0] ADR_FLAGS    = 4'h4;
  localparam logic [3:0] ADR_SCAN     = 4'h8;
  localparam int         LINE_CHARS   = 80;
  localparam logic [6:0] LINE_LAST    = 7'h4f;
  localparam logic [7:0] CNT_MAX      = 8'hff;
  localparam logic [7:0] FLAGS_RST    = 8'h00;
  localparam logic [4:0] BLANK_ROW    = 5'h08;
  localparam logic [2:0] BIT_LAST     = 3'h7;
  localparam logic [2:0] GREY_FULL    = 3'h7;
  localparam logic [3:0] STAT_NIBBLE  = 4'hf;
  localparam logic [2:0] FLAG_NONE    = 3'h7;
  // highlight control codes
  localparam logic [6:0] HL_REVERSE   = 7'h0e;
  localparam logic [6:0] HL_UNDER     = 7'h0f;
  localparam logic [6:0] HL_BLINK     = 7'h18;
  localparam logic [6:0] HL_SECURE    = 7'h19;
  localparam logic [6:0] HL_BRIGHT    = 7'h1a;
  localparam logic [6:0] HL_STOP      = 7'h1c;
  localparam logic [6:0] HL_FORMS_A   = 7'h1d;
  localparam logic [6:0] HL_ALL       = 7'h1e;
  localparam logic [6:0] HL_FORMS_B   = 7'h1f;
  // character status bit positions
  localparam int HB_REV = 0;
  localparam int HB_UND = 1;
  localparam int HB_BLK = 2;
  localparam int HB_SEC = 3;
  localparam int HB_BRT = 4;
  localparam int ST_BLANK = 5;
  localparam int ST_CURSOR = 6;
  // display flag bit positions
  localparam int FL_FIELD = 0;
  localparam int FL_LAST  = 1;
  localparam int FL_CBLINK = 2;
  localparam int FL_CURB  = 3;
  localparam int FL_WIDE  = 4;
  localparam int FL_NEG   = 5;
  localparam int FL_FORMS = 6;
endpackage : clvp_pkg

// ---- verif/clvp_cpu_model.sv ----
// display processor model: answers dma requests from a byte script
`timescale 1ns/100ps
module clvp_cpu_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       dma_req,
  output logic            dma_out,
  output logic      [7:0] dma_data,
  output logic            cursor_flag
);
  logic [7:0]  script[$];
  int unsigned idle;

  // one byte per request, random idle gap so both prompt and slow answers occur
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dma_out     <= 1'b0;
      dma_data    <= 8'h00;
      cursor_flag <= 1'b0;
      idle = 0;
    end else if (dma_out) begin
      dma_out     <= 1'b0;
      dma_data    <= ~dma_data; // bus released: no stale value left behind
      cursor_flag <= ~cursor_flag;
      idle = $urandom_range(3, 0);
    end else if (dma_req && script.size() > 0) begin
      if (idle > 0) begin
        idle--;
      end else begin
        dma_out     <= 1'b1; // only bytes that were asked for are sent
        dma_data    <= script.pop_front();
        cursor_flag <= 1'($urandom_range(1, 0));
      end
    end else begin
      dma_data <= ~dma_data;
    end
  end
endmodule : clvp_cpu_model

// ---- verif/tb_char_line_video_pipeline.sv ----
// self-checking bench for the character-line video pipeline
`timescale 1ns/100ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp); end end
module tb_char_line_video_pipeline;
  logic        clk_sys, rst_b, cyc, stb, we, q_flag, tick_n, ph4, pix, sync_req;
  logic [3:0]  adr, sel;
  logic [31:0] wdat, wb_dat_o, rd;
  logic [23:0] cg_data, cg_fix;
  logic [7:0]  dma_data, flags_exp, ch0;
  logic        wb_ack_o, dma_out, cursor_flag, dma_req, last_scan_line, dac_sync;
  logic [11:0] cg_addr;
  logic [3:0]  dac_level;
  logic [2:0]  ph_cnt;
  logic        pix_on, pix_one;
  int          n_errors, n_checks, cycles;

  clvp_core u_clvp_core (.clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .q_flag(q_flag), .horizontal_pixel_tick_n(tick_n),
    .display_cpu_phase_four(ph4), .dma_out(dma_out), .dma_data(dma_data),
    .cursor_flag(cursor_flag), .pixel_tick(pix), .cg_data(cg_data), .sync_req(sync_req),
    .dma_req(dma_req), .cg_addr(cg_addr), .last_scan_line(last_scan_line),
    .dac_level(dac_level), .dac_sync(dac_sync));
  clvp_cpu_model u_clvp_cpu_model (.clk_sys(clk_sys), .rst_b(rst_b), .dma_req(dma_req),
    .dma_out(dma_out), .dma_data(dma_data), .cursor_flag(cursor_flag));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // phase four every eighth cycle, random pixel traffic, hang guard
  always @(posedge clk_sys) begin
    ph_cnt  <= ph_cnt + 3'h1;
    ph4     <= (ph_cnt == 3'h3);
    pix     <= pix_on ? 1'($urandom_range(1, 0)) : pix_one; // single pixels in the pixel test
    cg_data <= pix_on ? 24'($urandom) : cg_fix;
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  // classic single wishbone cycle; only the run timeout ends the wait for ack
  task automatic wb_xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                         output logic [31:0] r);
    @(posedge clk_sys);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hf;
    do begin
      @(posedge clk_sys);
    end while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb_xfer

  // n horizontal pixel ticks, each long enough to be seen at a phase-four sample
  task automatic hticks(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      tick_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      tick_n <= 1'b1;
      repeat (8) @(posedge clk_sys);
    end
  endtask : hticks

  // one pixel tick, then wait until its grey level stands on the output
  task automatic pixel();
    @(posedge clk_sys);
    pix_one <= 1'b1;
    @(posedge clk_sys);
    pix_one <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : pixel

  // expected level in negative video: plain pixel, or a blank bright control cell
  function automatic logic [3:0] grey(input logic [2:0] bits, input logic bright_blank);
    logic [2:0] g;
    g = bright_blank ? 3'h7 : 3'h7 - bits; // lit bits go dark on a lit background
    grey = bright_blank ? {g, 1'b0} : {1'b0, g}; // bright doubles the level
  endfunction : grey

  task automatic drain();
    int n;
    n = 0;
    while (u_clvp_cpu_model.script.size() > 0 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (4) @(posedge clk_sys);
  endtask : drain

  initial begin
    {cyc, stb, we, q_flag, pix, sync_req, ph4} = '0;
    tick_n = 1'b1;
    pix_on = 1'b1;
    pix_one = 1'b0;
    cg_fix = 24'h0;
    adr = 4'h0;
    sel = 4'h0;
    wdat = 32'h0;
    cg_data = 24'h0;
    ph_cnt = 3'h0;
    rst_b = 1'b0;
    void'($urandom(32'hc262));
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    `CHK(dma_req, 1'b0)
    wb_xfer(1'b0, clvp_pkg::ADR_LINE_LEN, 32'h0, rd);
    `CHK(rd, 32'h0)
    wb_xfer(1'b0, 4'hc, 32'h0, rd);
    `CHK(rd, 32'h0)
    $display("test reset done");
    // two-character line: ones complement of 2
    wb_xfer(1'b1, clvp_pkg::ADR_LINE_LEN, 32'hfd, rd);
    wb_xfer(1'b0, clvp_pkg::ADR_LINE_LEN, 32'h0, rd);
    `CHK(rd, 32'h1fd)
    `CHK(dma_req, 1'b1)
    // status codes go ahead of the characters, random set or reset per flag
    for (int k = 0; k < 7; k++) begin
      flags_exp[k] = 1'($urandom_range(1, 0));
      u_clvp_cpu_model.script.push_back(8'hf0 + 8'(2 * k) + 8'(flags_exp[k]));
    end
    flags_exp[7] = 1'b0;
    drain();
    wb_xfer(1'b0, clvp_pkg::ADR_FLAGS, 32'h0, rd);
    `CHK(rd, {24'h0, flags_exp})
    $display("test status codes done");
    ch0 = {2'b01, 6'($urandom)};
    u_clvp_cpu_model.script.push_back(ch0);
    u_clvp_cpu_model.script.push_back({1'b0, clvp_pkg::HL_BRIGHT});
    drain();
    wb_xfer(1'b0, clvp_pkg::ADR_LINE_LEN, 32'h0, rd);
    `CHK(rd, 32'h1ff)
    `CHK(dma_req, 1'b0)
    wb_xfer(1'b1, clvp_pkg::ADR_LINE_LEN, 32'hff, rd);
    repeat (2) @(posedge clk_sys);
    `CHK(dma_req, 1'b0)
    $display("test line fill done");
    // scan counter from cleared value up to its carry
    q_flag <= 1'b1;
    repeat (2) @(posedge clk_sys);
    q_flag <= 1'b0;
    @(posedge clk_sys);
    `CHK(last_scan_line, 1'b0)
    hticks(254);
    `CHK(last_scan_line, 1'b0)
    hticks(1);
    `CHK(last_scan_line, 1'b1)
    hticks(1);
    `CHK(dma_req, 1'b1)
    u_clvp_cpu_model.script.push_back(8'hf8);
    drain();
    `CHK(dma_req, 1'b0)
    hticks(6);
    `CHK(last_scan_line, 1'b0)
    hticks(1);
    `CHK(last_scan_line, 1'b1)
    q_flag <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK(last_scan_line, 1'b0)
    q_flag <= 1'b0;
    $display("test scan counter done");
    sync_req <= 1'b1;
    repeat (3) @(posedge clk_sys);
    `CHK(dac_sync, 1'b1)
    `CHK(dac_level, 4'h0)
    sync_req <= 1'b0;
    $display("test sync level done");
    // pixel path: fixed generator data, plain character then a bright start code
    pix_on <= 1'b0;
    cg_fix <= 24'($urandom);
    wb_xfer(1'b1, clvp_pkg::ADR_FLAGS, 32'h20, rd);
    hticks(1);
    `CHK(cg_addr, {ch0[6:0], 1'b0, 4'h1})
    for (int i = 0; i < 10; i++) begin
      pixel();
      `CHK(dac_level, grey({cg_fix[23-i%8], cg_fix[15-i%8], cg_fix[7-i%8]}, i >= 8))
    end
    `CHK(cg_addr, {clvp_pkg::HL_STOP, 1'b0, 4'h1})
    $display("test pixel path done");
    conclude();
  end
endmodule : tb_char_line_video_pipeline
